// ==== logic/lcd_cmd_pkg.sv ====
// Shared constants and types of the serial LCD command core
package lcd_cmd_pkg;
    localparam int PTR_W = 5;
    localparam int CHARS = 13;
    localparam int GROUP_W = 5;
    localparam logic [4:0] CODE_LAST = 5'h0C;
    localparam logic [4:0] DOT_BASE = 5'h10;
    localparam logic [4:0] DOT_LAST = 5'h1C;
    localparam int WAIT_OSC_PERIODS = 21;
    localparam int OSC_PERIOD_CLKS = 1;
    localparam int WAIT_CYCLES = WAIT_OSC_PERIODS * OSC_PERIOD_CLKS;
    localparam int SYNC_CS = 0;
    localparam int SYNC_SI = 1;
    localparam int SYNC_CD = 2;
    localparam int SYNC_SCK = 3;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic RST_PANEL_ON = 1'b0;
    localparam logic RST_BLINK_OFF_STYLE = 1'b0;
    localparam logic RST_DOT_UNIT = 1'b0;
    localparam logic RST_BLINK_WR = 1'b0;
    localparam logic RST_READ_EN = 1'b0;
    localparam logic [2:0] OP_PANEL = 3'h4;
    localparam logic [2:0] OP_DOT_BLINK = 3'h6;
    localparam logic [2:0] OP_STYLE = 3'h1;
    localparam logic [2:0] OP_READBACK = 3'h3;

    typedef struct packed {
        logic is_cmd;
        logic [7:0] value;
    } serial_unit_t;

    typedef struct packed {
        logic [7:0] glyph_rom_addr;
        logic [GROUP_W-1:0] dots;
        logic char_blink;
        logic [GROUP_W-1:0] dot_blink;
    } scan_out_t;
endpackage

// ==== logic/lcd_serial_command_core.sv ====
// Serial command interpreter and display memories of a dot-matrix LCD controller
// Functional notes
// RULE_01: A five-bit pointer addresses all four display memories.
// RULE_02: Command 11x-AAAAA loads the pointer from its low five bits.
// RULE_03: Pointer steps after step command, char-blink command and every data byte.
// RULE_04: Character-code memory holds thirteen eight-bit glyph codes.
// RULE_05: Dot memory holds thirteen five-dot groups, sixty-five dots.
// RULE_06: Character-blink memory holds one bit per character position.
// RULE_07: Dot-blink memory holds thirteen five-dot groups.
// RULE_08: Stored code indexes the glyph ROM for its display position.
// RULE_09: Panel switch command turns the panel on or off by its flag.
// RULE_10: Char-blink command sets or clears blink at the pointer position.
// RULE_11: Unit command picks single-dot or five-dot dot-blink writing.
// RULE_12: Dot-blink write command starts or stops dot-blink writes.
// RULE_13: Blink style command picks all-off or all-on alternation.
// RULE_14: Pointer step command advances the pointer by one.
// RULE_15: Readback command drives or floats the serial output.
// RULE_16: Host waits twenty-one oscillator periods after every command.
// RULE_17: Dot bytes use low five bits, bit 4 is the first segment.
// RULE_18: Bytes arrive MSB first and are assembled in that order.
// RULE_19: Transfers are accepted only while chip select is high.
// RULE_20: Bits shift on rising shift clock, byte loads after eight.
// RULE_21: Command/data select is sampled on the eighth rising edge.
// RULE_22: Readback shifts the pointed byte MSB first on falling edges.
// RULE_23: Reset keeps memories, sets defaults, panel off, output floating.
// RULE_24: Code bytes above address 0x0C are dropped, pointer still steps.
// RULE_25: Dot groups start at address 0x10, one group per address.
// RULE_26: Chip select falling mid-byte discards the partial byte.
// RULE_27: Serial pins pass two-flop synchronisers before any logic.
`timescale 1ns/100ps
module lcd_serial_command_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Serial pins
    input wire logic cs,
    input wire logic si,
    input wire logic cd_sel,
    input wire logic shift_clock_pin,
    output logic so_out,
    output logic so_oe,
    // Mode state
    output logic panel_on,
    output logic blink_phase_bit,
    output logic dot_granularity_bit,
    output logic dot_blink_write_flag,
    output logic cmd_busy,
    output logic unit_overrun,
    // Display scan
    input wire logic [3:0] scan_pos,
    output lcd_cmd_pkg::scan_out_t scan_out
);
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic sck_prev;
        logic cs_prev;
        logic [7:0] in_shift;
        logic [3:0] bit_cnt;
        logic [lcd_cmd_pkg::PTR_W-1:0] ptr; // RULE_01
        logic panel_on;
        logic blink_off_style;
        logic dot_unit;
        logic blink_wr;
        logic read_en;
        logic reload;
        logic [7:0] out_shift;
        logic so_out;
        logic so_oe;
        logic [4:0] wait_cnt;
        logic busy;
        logic overrun;
        lcd_cmd_pkg::scan_out_t scan;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    logic [7:0] char_code_ram [lcd_cmd_pkg::CHARS];
    logic [lcd_cmd_pkg::GROUP_W-1:0] dot_pattern_ram [lcd_cmd_pkg::CHARS];
    logic char_blink_ram [lcd_cmd_pkg::CHARS];
    logic [lcd_cmd_pkg::GROUP_W-1:0] dot_blink_ram [lcd_cmd_pkg::CHARS];

    logic push;
    logic push_ready;
    logic exec_valid;
    lcd_cmd_pkg::serial_unit_t push_unit;
    logic exec;
    lcd_cmd_pkg::serial_unit_t ex;
    logic code_we;
    logic dot_we;
    logic dblink_we;
    logic cblink_we;
    logic [3:0] wr_idx;
    logic [lcd_cmd_pkg::GROUP_W-1:0] dblink_data;
    logic [7:0] read_byte;
    logic sck_rise;
    logic sck_fall;
    logic cs_now;
    logic in_code;
    logic in_dot;

    // Depth two lets two bytes queue while the previous one, already taken out, serves its wait time
    unit_buffer #(
        .WIDTH($bits(lcd_cmd_pkg::serial_unit_t))
    ) u_buffer (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_unit),
        .out_valid(exec_valid),
        .out_ready(exec),
        .out_data(ex)
    );

    always_comb
    begin
        in_code = (s.ptr <= lcd_cmd_pkg::CODE_LAST);
        in_dot = (s.ptr >= lcd_cmd_pkg::DOT_BASE) && (s.ptr <= lcd_cmd_pkg::DOT_LAST);
        if (in_code)
            read_byte = char_code_ram[s.ptr[3:0]];
        else if (in_dot)
            read_byte = {3'h0, dot_pattern_ram[4'(s.ptr - lcd_cmd_pkg::DOT_BASE)]};
        else
            read_byte = 8'h00;
    end

    always_comb
    begin
        next_s = s;
        next_s.reload = 1'b0;
        push = 1'b0;
        code_we = 1'b0;
        dot_we = 1'b0;
        dblink_we = 1'b0;
        cblink_we = 1'b0;
        wr_idx = in_code ? s.ptr[3:0] : 4'(s.ptr - lcd_cmd_pkg::DOT_BASE);
        // Second stage alone reads the first stage
        next_s.sync1 = {shift_clock_pin, cd_sel, si, cs}; // RULE_27
        next_s.sync2 = s.sync1; // RULE_27
        next_s.sck_prev = s.sync2[lcd_cmd_pkg::SYNC_SCK];
        next_s.cs_prev = s.sync2[lcd_cmd_pkg::SYNC_CS];
        cs_now = s.sync2[lcd_cmd_pkg::SYNC_CS];
        sck_rise = s.sync2[lcd_cmd_pkg::SYNC_SCK] && !s.sck_prev;
        sck_fall = !s.sync2[lcd_cmd_pkg::SYNC_SCK] && s.sck_prev;
        push_unit.is_cmd = s.sync2[lcd_cmd_pkg::SYNC_CD]; // RULE_21
        push_unit.value = {s.in_shift[6:0], s.sync2[lcd_cmd_pkg::SYNC_SI]};

        if (!cs_now)
            next_s.bit_cnt = 4'h0; // RULE_19 RULE_26
        else if (sck_rise)
        begin
            next_s.in_shift = push_unit.value; // RULE_18 RULE_20
            if (s.bit_cnt == lcd_cmd_pkg::LAST_BIT)
            begin
                push = 1'b1; // RULE_20
                next_s.bit_cnt = 4'h0;
            end
            else
                next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
        // A byte that finds both entries full is lost; the flag stays up until reset
        if (push && !push_ready)
            next_s.overrun = 1'b1;

        // Wait time after each executed unit
        exec = exec_valid && !s.busy; // RULE_16
        if (s.busy)
        begin
            if (s.wait_cnt == 5'h0)
                next_s.busy = 1'b0;
            else
                next_s.wait_cnt = s.wait_cnt - 5'h1;
        end
        if (exec)
        begin
            next_s.busy = 1'b1;
            next_s.wait_cnt = 5'(lcd_cmd_pkg::WAIT_CYCLES - 2);
            next_s.reload = 1'b1;
            if (ex.is_cmd)
            begin
                if (ex.value[7:6] == 2'b11)
                    next_s.ptr = ex.value[4:0]; // RULE_02
                else if (!ex.value[7] && ex.value[3:2] == 2'b00)
                begin
                    cblink_we = in_code; // RULE_10
                    next_s.ptr = s.ptr + 5'h1; // RULE_03
                end
                else if (ex.value[7:5] == 3'b100)
                begin
                    if (ex.value[3:1] == lcd_cmd_pkg::OP_PANEL)
                        next_s.panel_on = ex.value[0]; // RULE_09
                    else if (ex.value[3:1] == lcd_cmd_pkg::OP_DOT_BLINK && ex.value[4])
                        next_s.dot_unit = ex.value[0]; // RULE_11
                    else if (ex.value[3:1] == lcd_cmd_pkg::OP_DOT_BLINK)
                        next_s.blink_wr = ex.value[0]; // RULE_12
                    else if (ex.value[3:1] == lcd_cmd_pkg::OP_STYLE)
                        next_s.blink_off_style = ex.value[0]; // RULE_13
                    else if (ex.value[3:1] == lcd_cmd_pkg::OP_READBACK)
                        next_s.read_en = ex.value[0]; // RULE_15
                    else if (ex.value[3] && ex.value[1])
                        next_s.ptr = s.ptr + 5'h1; // RULE_14 RULE_03
                end
            end
            else
            begin
                code_we = in_code; // RULE_24
                dot_we = in_dot && !s.blink_wr; // RULE_25
                dblink_we = in_dot && s.blink_wr; // RULE_12
                next_s.ptr = s.ptr + 5'h1; // RULE_03
            end
        end

        // Readback shifter
        // The fall that closes a byte comes after the reload for the next one,
        // so only falls inside a byte shift and the fresh MSB survives
        if ((cs_now && !s.cs_prev) || s.reload)
            next_s.out_shift = read_byte;
        else if (cs_now && sck_fall && s.bit_cnt != 4'h0)
            next_s.out_shift = {s.out_shift[6:0], 1'b0}; // RULE_22
        next_s.so_out = next_s.out_shift[7]; // RULE_22
        next_s.so_oe = cs_now && next_s.read_en; // RULE_22 RULE_15

        // Scan port for the drive logic
        if (scan_pos < 4'(lcd_cmd_pkg::CHARS))
        begin
            next_s.scan.glyph_rom_addr = char_code_ram[scan_pos]; // RULE_08
            next_s.scan.dots = dot_pattern_ram[scan_pos];
            next_s.scan.char_blink = char_blink_ram[scan_pos];
            next_s.scan.dot_blink = dot_blink_ram[scan_pos];
        end
        else
            next_s.scan = '0;
    end

    // Single-dot mode sets the marked dots of the group and never clears a dot
    always_comb
    begin
        if (!s.dot_unit)
            dblink_data = ex.value[4:0]; // RULE_11 RULE_17
        else
            dblink_data = dot_blink_ram[wr_idx] | ex.value[4:0]; // RULE_11 RULE_17
    end

    // Memories have no reset so that reset keeps their contents
    always_ff @(posedge mclk)
    begin
        if (code_we)
            char_code_ram[wr_idx] <= ex.value; // RULE_04
        if (dot_we)
            dot_pattern_ram[wr_idx] <= ex.value[4:0]; // RULE_05 RULE_17
        if (dblink_we)
            dot_blink_ram[wr_idx] <= dblink_data; // RULE_07
        if (cblink_we)
            char_blink_ram[wr_idx] <= ex.value[1]; // RULE_06 RULE_10
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '0;
            s.panel_on <= lcd_cmd_pkg::RST_PANEL_ON; // RULE_23
            s.blink_off_style <= lcd_cmd_pkg::RST_BLINK_OFF_STYLE; // RULE_23
            s.dot_unit <= lcd_cmd_pkg::RST_DOT_UNIT; // RULE_23
            s.blink_wr <= lcd_cmd_pkg::RST_BLINK_WR;
            s.read_en <= lcd_cmd_pkg::RST_READ_EN; // RULE_23
        end
        else
            s <= next_s;
    end

    assign so_out = s.so_out;
    assign so_oe = s.so_oe;
    assign panel_on = s.panel_on;
    assign blink_phase_bit = s.blink_off_style;
    assign dot_granularity_bit = s.dot_unit;
    assign dot_blink_write_flag = s.blink_wr;
    assign cmd_busy = s.busy;
    assign unit_overrun = s.overrun;
    assign scan_out = s.scan;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    ptr_load_a: assert property (exec && ex.is_cmd && ex.value[7:6] == 2'b11 |=> s.ptr == $past(ex.value[4:0])) // RULE_02
        else $error("pointer load did not take the command value");
    ptr_step_a: assert property (exec && !ex.is_cmd |=> s.ptr == $past(s.ptr) + 5'h1) // RULE_03
        else $error("pointer did not step after a data byte");
    // Mode command effects appear the cycle after execution
    panel_cmd_a: assert property (exec && ex.is_cmd && ex.value[7:5] == 3'b100 && ex.value[3:0] == 4'h9 // RULE_09
        |=> panel_on)
        else $error("panel switch command did not turn the panel on");
    panel_off_a: assert property (exec && ex.is_cmd && ex.value[7:5] == 3'b100 && ex.value[3:0] == 4'h8 // RULE_09
        |=> !panel_on)
        else $error("panel switch command did not turn the panel off");
    style_cmd_a: assert property (exec && ex.is_cmd && ex.value[7:5] == 3'b100 && ex.value[3:1] == 3'h1 // RULE_13
        |=> blink_phase_bit == $past(ex.value[0]))
        else $error("blink style not taken from command");
    unit_mode_a: assert property (exec && ex.is_cmd && ex.value[7:4] == 4'h9 && ex.value[3:1] == 3'h6 // RULE_11
        |=> dot_granularity_bit == $past(ex.value[0]))
        else $error("dot blink unit not taken from command");
    blink_wr_a: assert property (exec && ex.is_cmd && ex.value[7:4] == 4'h8 && ex.value[3:1] == 3'h6 // RULE_12
        |=> dot_blink_write_flag == $past(ex.value[0]))
        else $error("dot blink write flag not taken from command");
    read_en_a: assert property (exec && ex.is_cmd && ex.value[7:5] == 3'b100 && ex.value[3:1] == 3'h3 // RULE_15
        |=> s.read_en == $past(ex.value[0]))
        else $error("readback enable not taken from command");
    step_cmd_a: assert property (exec && ex.is_cmd && ex.value[7:5] == 3'b100 && ex.value[3:1] == 3'h5 // RULE_14
        |=> s.ptr == $past(s.ptr) + 5'h1)
        else $error("step command did not advance the pointer");
    blink_step_a: assert property (exec && ex.is_cmd && !ex.value[7] && ex.value[3:2] == 2'b00 // RULE_10
        |=> s.ptr == $past(s.ptr) + 5'h1)
        else $error("character blink command did not advance the pointer");
    cblink_limit_a: assert property (cblink_we |-> s.ptr <= lcd_cmd_pkg::CODE_LAST) // RULE_06
        else $error("character blink stored beyond the last position");

    // Readback output
    so_float_a: assert property (!s.read_en |-> !so_oe) // RULE_15
        else $error("serial output driven while readback is disabled");
    so_cs_a: assert property (!s.sync2[lcd_cmd_pkg::SYNC_CS] |=> !so_oe) // RULE_22
        else $error("serial output driven while deselected");
    so_shift_a: assert property (cs_now && s.cs_prev && sck_fall && s.bit_cnt != 4'h0 && !s.reload // RULE_22
        |=> s.out_shift == {$past(s.out_shift[6:0]), 1'b0})
        else $error("readback byte did not shift on a falling shift clock");
    cs_abort_a: assert property (!s.sync2[lcd_cmd_pkg::SYNC_CS] |=> s.bit_cnt == 4'h0 && !push) // RULE_26
        else $error("partial byte kept after chip select fell");
    wait_time_a: assert property (exec |=> cmd_busy [*8] ##1 cmd_busy [*8] ##1 !exec [*4]) // RULE_16
        else $error("next unit taken before the wait time");
    code_limit_a: assert property (exec && !ex.is_cmd && s.ptr > lcd_cmd_pkg::CODE_LAST |-> !code_we) // RULE_24
        else $error("character code stored beyond the last position");
    byte_cd_a: assert property (push |-> s.bit_cnt == lcd_cmd_pkg::LAST_BIT && sck_rise) // RULE_20 RULE_21
        else $error("byte loaded on a wrong shift clock");
    dot_limit_a: assert property (exec && !ex.is_cmd && !in_dot |-> !dot_we && !dblink_we) // RULE_25
        else $error("dot group written outside the dot address range");
    sel_excl_a: assert property (!(dot_we && dblink_we)) // RULE_12
        else $error("dot data and dot blink data written at once");
    scan_blank_a: assert property (scan_pos > 4'hC |=> scan_out == '0) // RULE_08
        else $error("scan port shows data beyond the last position");

    cmd_seen_c: cover property (exec && ex.is_cmd);
    data_seen_c: cover property (exec && !ex.is_cmd && code_we);
    readback_c: cover property (so_oe ##1 sck_fall);
    queued_c: cover property (exec_valid && cmd_busy);
    overrun_c: cover property (push && !push_ready);
endmodule

// ==== logic/unit_buffer.sv ====
// Two-entry valid/ready buffer between the serial assembler and the executor
`timescale 1ns/100ps
module unit_buffer #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s;
    buf_state_t next_s;
    logic push;
    logic pop;

    always_comb
    begin
        next_s = s;
        push = in_valid && (s.count != 2'h2);
        pop = out_ready && (s.count != 2'h0);
        if (push)
        begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = ~s.wr_ptr;
        end
        if (pop)
            next_s.rd_ptr = ~s.rd_ptr;
        if (push && !pop)
            next_s.count = s.count + 2'h1;
        else if (pop && !push)
            next_s.count = s.count - 2'h1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign in_ready = (s.count != 2'h2);
    assign out_valid = (s.count != 2'h0);
    assign out_data = s.mem[s.rd_ptr];

    buf_count_a: assert property (@(posedge mclk) disable iff (!arst_n) s.count <= 2'h2)
        else $error("buffer holds more than two entries");
endmodule

// ==== tb/lcd_host_model.sv ====
// Host model driving the serial command pins of the LCD core
`timescale 1ns/100ps
module lcd_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic cs,
    output logic si,
    output logic cd_sel,
    output logic shift_clock_pin,
    input wire logic so_out
);
    logic [7:0] rd;

    initial
    begin
        cs = 1'b0;
        si = 1'b1;
        cd_sel = 1'b1;
        shift_clock_pin = 1'b0;
        rd = 8'h00;
    end

    task automatic sel(input logic v);
        cs <= v;
        repeat (4) @(posedge mclk);
    endtask

    // The type line shows the wrong kind until the last bit, so an early sample is caught
    task automatic xfer(input logic c, input logic [7:0] b, input int n, input int gap);
        for (int i = 7; i > 7 - n; i--)
        begin
            si <= b[i];
            cd_sel <= (i == 0) ? c : ~c;
            repeat (8) @(posedge mclk);
            // Read data is taken before the rise; the core moves it on the fall
            rd[i] = so_out;
            shift_clock_pin <= 1'b1;
            repeat (8) @(posedge mclk);
            shift_clock_pin <= 1'b0;
        end
        si <= ~si;
        cd_sel <= ~cd_sel;
        repeat (gap) @(posedge mclk);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial LCD command core
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] scan_pos = 4'h0;
    logic cs, si, cd_sel, shift_clock_pin, so_out, so_oe;
    logic panel_on, blink_phase_bit, dot_granularity_bit, dot_blink_write_flag, cmd_busy, unit_overrun;
    lcd_cmd_pkg::scan_out_t scan_out;
    integer seed = 32'h1B05;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int busy_run = 0;
    int busy_last = 0;
    int p, n;
    logic [7:0] code [0:13];
    logic [4:0] dots [0:12];
    logic [4:0] m;
    logic [7:0] w, w2;
    logic [7:0] ops [0:4] = '{8'h88, 8'h82, 8'h9C, 8'h8C, 8'h86};

    always #2.5 mclk = ~mclk;

    lcd_host_model host (.mclk(mclk), .cs(cs), .si(si), .cd_sel(cd_sel), .shift_clock_pin(shift_clock_pin),
        .so_out(so_out));

    lcd_serial_command_core DUT (.mclk(mclk), .arst_n(arst_n), .cs(cs), .si(si), .cd_sel(cd_sel),
        .shift_clock_pin(shift_clock_pin), .so_out(so_out), .so_oe(so_oe), .panel_on(panel_on),
        .blink_phase_bit(blink_phase_bit), .dot_granularity_bit(dot_granularity_bit),
        .dot_blink_write_flag(dot_blink_write_flag), .cmd_busy(cmd_busy), .unit_overrun(unit_overrun),
        .scan_pos(scan_pos), .scan_out(scan_out));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] b);
        host.xfer(1'b1, b, 8, 40);
    endtask

    task automatic dat(input logic [7:0] b);
        host.xfer(1'b0, b, 8, 40);
    endtask

    task automatic look(input int q);
        scan_pos <= q[3:0];
        repeat (3) @(posedge mclk);
    endtask

    task automatic modes;
        chk({3'h0, panel_on, blink_phase_bit, dot_granularity_bit, dot_blink_write_flag, so_oe}, {3'h0, m});
    endtask

    // Unused pointer ranges read back as zero
    function automatic logic [7:0] rb(input int q);
        if (q <= 12)
            return code[q];
        if (q >= 16 && q <= 28)
            return {3'h0, dots[q - 16]};
        return 8'h00;
    endfunction

    always @(posedge mclk)
    begin
        cyc++;
        if (cmd_busy === 1'b1)
            busy_run++;
        else if (busy_run != 0)
        begin
            busy_last = busy_run;
            busy_run = 0;
        end
        if (cyc == 30000)
        begin
            fail_count++;
            results;
        end
    end

    initial
    begin
        m = 5'h00;
        repeat (6) @(posedge mclk);
        modes;
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        host.sel(1'b1);
        for (n = 0; n < 18; n++)
        begin
            p = (n < 10) ? n / 2 : {$random(seed)} % 5;
            w = (n < 10) ? n % 2 : $random(seed);
            m[4 - p] = w[0];
            cmd(ops[p] | {7'h0, w[0]});
            modes;
        end
        cmd(8'h8C);
        cmd(8'h9C);
        cmd(8'h87);
        m[2:0] = 3'b001;
        $display("test modes done");
        cmd(8'hE0);
        for (p = 0; p < 14; p++)
        begin
            code[p] = $random(seed);
            dat(code[p]);
        end
        for (p = 0; p < 14; p++)
        begin
            look(p);
            chk(scan_out.glyph_rom_addr, (p < 13) ? code[p] : 8'h00);
        end
        for (n = 0; n < 5; n++)
        begin
            p = {$random(seed)} % 13;
            cmd(8'hC0 | p[7:0]);
            cmd(8'h8A);
            chk(host.rd, rb(p));
            cmd(8'h8A);
            chk(host.rd, rb(p + 1));
        end
        $display("test codes done");
        cmd(8'hD0);
        for (p = 0; p < 13; p++)
        begin
            w = $random(seed);
            dots[p] = w[4:0];
            dat(w);
        end
        for (p = 0; p < 13; p++)
        begin
            look(p);
            chk({3'h0, scan_out.dots}, {3'h0, dots[p]});
        end
        for (n = 0; n < 3; n++)
        begin
            p = 16 + {$random(seed)} % 13;
            cmd(8'hC0 | p[7:0]);
            cmd(8'h8A);
            chk(host.rd, rb(p));
        end
        $display("test dots done");
        p = {$random(seed)} % 13;
        cmd(8'h8D);
        cmd(8'hC0 | (8'h10 + p[7:0]));
        w = $random(seed);
        dat(w);
        cmd(8'h9D);
        cmd(8'hC0 | (8'h10 + p[7:0]));
        w2 = $random(seed);
        dat(w2);
        look(p);
        chk({3'h0, scan_out.dot_blink}, {3'h0, w[4:0] | w2[4:0]});
        chk({3'h0, scan_out.dots}, {3'h0, dots[p]});
        cmd(8'h8C);
        cmd(8'h9C);
        $display("test dot blink done");
        p = {$random(seed)} % 12;
        cmd(8'hC0 | p[7:0]);
        cmd(8'h72);
        cmd(8'h8A);
        chk(host.rd, rb(p + 1));
        look(p);
        chk(scan_out.char_blink, 8'h01);
        cmd(8'hC0 | p[7:0]);
        cmd(8'h01);
        look(p);
        chk(scan_out.char_blink, 8'h00);
        $display("test char blink done");
        host.xfer(1'b1, 8'h8A, 8, 0);
        n = 0;
        while (cmd_busy === 1'b1 && n < 100)
        begin
            n++;
            @(posedge mclk);
        end
        // One more edge lets the run counter record the finished busy run
        @(posedge mclk);
        // The executing cycle and the busy cycles after it make up the wait
        chk(busy_last[7:0] + 8'h01, 8'(lcd_cmd_pkg::WAIT_CYCLES));
        cmd(8'h88);
        host.xfer(1'b1, 8'h89, 3, 5);
        host.sel(1'b0);
        chk(so_oe, 8'h00);
        host.xfer(1'b1, 8'h89, 8, 40);
        chk(panel_on, 8'h00);
        host.sel(1'b1);
        cmd(8'h89);
        chk(panel_on, 8'h01);
        $display("test framing done");
        m = 5'h00;
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        modes;
        arst_n <= 1'b1;
        look(0);
        chk(scan_out.glyph_rom_addr, code[0]);
        chk(unit_overrun, 8'h00);
        $display("test reset done");
        results;
    end
endmodule
